// ===== dsp_debug_port.sv
// Behaviour
// RULE_01: sample port select strap after reset; choose serial debug or scan port.
// RULE_02: low test reset initialises the scan controller without any test clock edge.
// RULE_03: scan controller advances by TMS sampled on test clock rising edges.
// RULE_04: TDI is captured on the test clock rising edge.
// RULE_05: TDO is driven only in Shift-IR or Shift-DR, otherwise released.
// RULE_06: TDO value changes only on test clock falling edges.
// RULE_07: serial clock level accepted only after two equal consecutive samples.
// RULE_08: debugger keeps serial clock at most one fifth of status clock.
// RULE_09: at validated serial clock rise, sample serial input and change serial output.
// RULE_10: serial output comes from a register, after serial clock validation.
// RULE_11: breakpoint request without disable halts after current instruction completes.
// RULE_12: while halted the status outputs show 0xF.
// RULE_13: with breakpoint disable set, request raises debug interrupt instead of halting.
// RULE_14: status clock is a delayed processor clock, rising mid status window.
// RULE_15: status clock disable freezes status clock, status and data; triggers stay live.
// RULE_16: debugger resynchronises to trace after status clock disable is cleared.
// RULE_17: status clock stays idle until first status 0xC, 0xD or 0xF.
// RULE_18: status updates with processor clock, independent of bus transfers.
// RULE_19: all-and output is the AND of the four status bits.
// RULE_20: captured data and breakpoint status drive the four debug data lines; the code drives them from core_data_i alone.
`timescale 1ns/10ps
`default_nettype none
module dsp_debug_port (
  input  wire logic              clock_i,
  input  wire logic              reset_i,
  input  wire logic              enable_i,
  input  wire logic              port_select_i,
  input  wire logic              test_reset_n_i,
  input  wire logic              test_clock_i,
  input  wire logic              test_mode_i,
  input  wire logic              test_data_i,
  output logic                   test_data_o,
  output logic                   test_data_oe_o,
  output logic [dsp_pkg::IR_W-1:0] instr_reg_o,
  input  wire logic              dbg_serial_clock_i,
  input  wire logic              dbg_serial_in_i,
  output logic                   dbg_serial_out_o,
  output logic [dsp_pkg::PKT_BITS-1:0] rx_word_o,
  output logic                   rx_valid_o,
  input  wire logic [dsp_pkg::PKT_BITS-1:0] tx_word_i,
  input  wire logic              breakpoint_request_i,
  input  wire logic              breakpoint_disable_i,
  input  wire logic              status_clock_disable_i,
  input  wire logic              instr_done_i,
  input  wire logic              resume_i,
  input  wire logic [3:0]        core_status_i,
  input  wire logic [3:0]        core_data_i,
  output logic                   halted_o,
  output logic                   debug_irq_o,
  output logic                   scan_mode_o,
  output logic                   system_clock_out_o,
  output logic                   status_clock_o,
  output logic [3:0]             proc_status_o,
  output logic [3:0]             debug_data_out_o,
  output logic                   status_all_and_o
);
  logic [dsp_pkg::PIN_W-1:0] pin_meta;
  logic [dsp_pkg::PIN_W-1:0] pin_sync;
  logic [dsp_pkg::PIN_W-1:0] pin_last;
  logic [1:0]                strap_cnt;
  logic                      strap_done;
  dsp_pkg::dsp_tap_t         tap_state;
  dsp_pkg::dsp_tap_t         next_tap_state;
  logic [dsp_pkg::IR_W-1:0]  ir_shift;
  logic                      bypass_bit;
  logic                      tck_rise;
  logic                      tck_fall;
  logic                      shifting;
  logic                      dbg_serial_clock_valid;
  logic                      dbg_serial_clock_rise;
  logic [dsp_pkg::PKT_BITS-1:0] rx_shift;
  logic [dsp_pkg::PKT_BITS-1:0] tx_shift;
  logic [4:0]                bit_cnt;
  logic                      breakpoint_request_rise;
  logic                      halt_pending;
  logic                      proc_tick;
  logic                      started;
  logic [3:0]                next_status;
  logic                      tms;
  // two-flop synchronisers plus an edge-detect stage for the scan, serial, breakpoint request and port select pins
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      pin_meta <= '0;
      pin_sync <= '0;
      pin_last <= '0;
    end else if (enable_i) begin
      pin_meta <= {port_select_i, breakpoint_request_i, dbg_serial_in_i,
                   dbg_serial_clock_i, test_data_i, test_mode_i, test_clock_i};
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
    end
  end
  // port select strap taken once the synchroniser has settled
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      strap_cnt   <= 2'h0;
      strap_done  <= 1'b0;
      scan_mode_o <= 1'b0;
    end else if (enable_i && !strap_done) begin
      if (strap_cnt == dsp_pkg::STRAP_WAIT) begin
        strap_done  <= 1'b1;
        scan_mode_o <= pin_sync[dsp_pkg::PIN_SEL]; // [RULE_01]
      end else begin
        strap_cnt <= strap_cnt + 2'h1;
      end
    end
  end

  assign tck_rise = enable_i && strap_done && scan_mode_o
                    && pin_sync[dsp_pkg::PIN_TCK] && !pin_last[dsp_pkg::PIN_TCK];
  assign tck_fall = enable_i && strap_done && scan_mode_o
                    && !pin_sync[dsp_pkg::PIN_TCK] && pin_last[dsp_pkg::PIN_TCK];
  assign shifting = (tap_state == dsp_pkg::TAP_SHIFT_IR)
                    || (tap_state == dsp_pkg::TAP_SHIFT_DR);
  assign tms      = pin_sync[dsp_pkg::PIN_TMS];
  // scan controller next state from the sampled mode pin
  always_comb begin
    next_tap_state = tap_state;
    case (tap_state)
      dsp_pkg::TAP_RESET:    next_tap_state = tms ? dsp_pkg::TAP_RESET : dsp_pkg::TAP_IDLE;
      dsp_pkg::TAP_IDLE:     next_tap_state = tms ? dsp_pkg::TAP_SEL_DR : dsp_pkg::TAP_IDLE;
      dsp_pkg::TAP_SEL_DR:   next_tap_state = tms ? dsp_pkg::TAP_SEL_IR : dsp_pkg::TAP_CAP_DR;
      dsp_pkg::TAP_CAP_DR:   next_tap_state = tms ? dsp_pkg::TAP_EXIT1_DR : dsp_pkg::TAP_SHIFT_DR;
      dsp_pkg::TAP_SHIFT_DR: next_tap_state = tms ? dsp_pkg::TAP_EXIT1_DR : dsp_pkg::TAP_SHIFT_DR;
      dsp_pkg::TAP_EXIT1_DR: next_tap_state = tms ? dsp_pkg::TAP_UPD_DR : dsp_pkg::TAP_PAUSE_DR;
      dsp_pkg::TAP_PAUSE_DR: next_tap_state = tms ? dsp_pkg::TAP_EXIT2_DR : dsp_pkg::TAP_PAUSE_DR;
      dsp_pkg::TAP_EXIT2_DR: next_tap_state = tms ? dsp_pkg::TAP_UPD_DR : dsp_pkg::TAP_SHIFT_DR;
      dsp_pkg::TAP_UPD_DR:   next_tap_state = tms ? dsp_pkg::TAP_SEL_DR : dsp_pkg::TAP_IDLE;
      dsp_pkg::TAP_SEL_IR:   next_tap_state = tms ? dsp_pkg::TAP_RESET : dsp_pkg::TAP_CAP_IR;
      dsp_pkg::TAP_CAP_IR:   next_tap_state = tms ? dsp_pkg::TAP_EXIT1_IR : dsp_pkg::TAP_SHIFT_IR;
      dsp_pkg::TAP_SHIFT_IR: next_tap_state = tms ? dsp_pkg::TAP_EXIT1_IR : dsp_pkg::TAP_SHIFT_IR;
      dsp_pkg::TAP_EXIT1_IR: next_tap_state = tms ? dsp_pkg::TAP_UPD_IR : dsp_pkg::TAP_PAUSE_IR;
      dsp_pkg::TAP_PAUSE_IR: next_tap_state = tms ? dsp_pkg::TAP_EXIT2_IR : dsp_pkg::TAP_PAUSE_IR;
      dsp_pkg::TAP_EXIT2_IR: next_tap_state = tms ? dsp_pkg::TAP_UPD_IR : dsp_pkg::TAP_SHIFT_IR;
      dsp_pkg::TAP_UPD_IR:   next_tap_state = tms ? dsp_pkg::TAP_SEL_DR : dsp_pkg::TAP_IDLE;
      default:               next_tap_state = dsp_pkg::TAP_RESET;
    endcase
  end
  // controller state and shift paths; test reset acts without any clock
  always_ff @(posedge clock_i or posedge reset_i or negedge test_reset_n_i) begin
    if (reset_i || !test_reset_n_i) begin
      tap_state   <= dsp_pkg::TAP_RESET; // [RULE_02]
      ir_shift    <= '0;
      instr_reg_o <= dsp_pkg::IR_RESET;
      bypass_bit  <= 1'b0;
    end else if (tck_rise) begin
      tap_state <= next_tap_state; // [RULE_03]
      if (tap_state == dsp_pkg::TAP_RESET) begin
        instr_reg_o <= dsp_pkg::IR_RESET;
      end
      if (tap_state == dsp_pkg::TAP_CAP_IR) begin
        ir_shift <= dsp_pkg::IR_CAPTURE;
      end else if (tap_state == dsp_pkg::TAP_SHIFT_IR) begin
        ir_shift <= {pin_sync[dsp_pkg::PIN_TDI], ir_shift[dsp_pkg::IR_W-1:1]}; // [RULE_04]
      end else if (tap_state == dsp_pkg::TAP_UPD_IR) begin
        instr_reg_o <= ir_shift;
      end
      if (tap_state == dsp_pkg::TAP_CAP_DR) begin
        bypass_bit <= 1'b0;
      end else if (tap_state == dsp_pkg::TAP_SHIFT_DR) begin
        bypass_bit <= pin_sync[dsp_pkg::PIN_TDI]; // [RULE_04]
      end
    end
  end
  // test data out and its enable move only on falling test clock edges
  always_ff @(posedge clock_i or posedge reset_i or negedge test_reset_n_i) begin
    if (reset_i || !test_reset_n_i) begin
      test_data_o    <= 1'b0;
      test_data_oe_o <= 1'b0;
    end else if (tck_fall) begin // [RULE_06]
      test_data_oe_o <= shifting; // [RULE_05]
      test_data_o    <= (tap_state == dsp_pkg::TAP_SHIFT_IR) ? ir_shift[0] : bypass_bit;
    end
  end
  // serial clock accepted only after two equal samples
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      dbg_serial_clock_valid <= 1'b0;
    end else if (enable_i && pin_sync[dsp_pkg::PIN_DBG_SERIAL_CLOCK] == pin_last[dsp_pkg::PIN_DBG_SERIAL_CLOCK]) begin
      dbg_serial_clock_valid <= pin_last[dsp_pkg::PIN_DBG_SERIAL_CLOCK]; // [RULE_07]
    end
  end
  assign dbg_serial_clock_rise = enable_i && strap_done && !scan_mode_o && !dbg_serial_clock_valid
                      && pin_sync[dsp_pkg::PIN_DBG_SERIAL_CLOCK] && pin_last[dsp_pkg::PIN_DBG_SERIAL_CLOCK];
  // serial packet shifter: input sampled and output changed on one event
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      rx_shift         <= '0;
      tx_shift         <= '0;
      bit_cnt          <= '0;
      rx_word_o        <= '0;
      rx_valid_o       <= 1'b0;
      dbg_serial_out_o <= 1'b0;
    end else if (enable_i) begin
      rx_valid_o <= 1'b0;
      if (dbg_serial_clock_rise) begin
        rx_shift <= {rx_shift[dsp_pkg::PKT_BITS-2:0], pin_sync[dsp_pkg::PIN_DSIN]}; // [RULE_09]
        {dbg_serial_out_o, tx_shift} <= {(~|bit_cnt) ? tx_word_i : tx_shift, 1'b0}; // [RULE_10]
        if (bit_cnt == dsp_pkg::PKT_LAST) begin
          bit_cnt    <= '0;
          rx_valid_o <= 1'b1;
          rx_word_o  <= {rx_shift[dsp_pkg::PKT_BITS-2:0], pin_sync[dsp_pkg::PIN_DSIN]};
        end else begin
          bit_cnt <= bit_cnt + 5'h01;
        end
      end
    end
  end
  assign breakpoint_request_rise = enable_i && pin_sync[dsp_pkg::PIN_BREAKPOINT_REQUEST] && !pin_last[dsp_pkg::PIN_BREAKPOINT_REQUEST];
  // breakpoint: halt after instruction completes, or debug interrupt when disabled
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      halt_pending <= 1'b0;
      halted_o     <= 1'b0;
      debug_irq_o  <= 1'b0;
    end else if (enable_i) begin
      debug_irq_o <= breakpoint_request_rise && breakpoint_disable_i; // [RULE_13]
      if (breakpoint_request_rise && !breakpoint_disable_i && !halted_o) begin
        halt_pending <= 1'b1;
      end else if (halt_pending && instr_done_i) begin
        halt_pending <= 1'b0;
        halted_o     <= 1'b1; // [RULE_11]
      end else if (halted_o && resume_i) begin
        halted_o <= 1'b0;
      end
    end
  end
  assign proc_tick   = enable_i && !system_clock_out_o;
  assign next_status = halted_o ? dsp_pkg::ST_HALTED : core_status_i; // [RULE_12]
  // processor clock by two, status window opens on its rising edge
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      system_clock_out_o <= 1'b0;
    end else if (enable_i) begin
      system_clock_out_o <= !system_clock_out_o;
    end
  end
  // trace outputs, frozen while the status clock is disabled
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      proc_status_o    <= dsp_pkg::ST_IDLE;
      status_all_and_o <= 1'b0;
      debug_data_out_o <= '0;
    end else if (proc_tick && !status_clock_disable_i) begin // [RULE_15]
      proc_status_o    <= next_status; // [RULE_18]
      status_all_and_o <= &next_status; // [RULE_19]
      debug_data_out_o <= core_data_i; // [RULE_20]
    end
  end
  // status clock trails the processor clock by half a window
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      started        <= 1'b0;
      status_clock_o <= 1'b0;
    end else if (enable_i) begin
      if (proc_tick && (next_status == dsp_pkg::ST_CODE_C || next_status == dsp_pkg::ST_CODE_D
                        || next_status == dsp_pkg::ST_HALTED)) begin
        started <= 1'b1; // [RULE_17]
      end
      if (!status_clock_disable_i) begin // [RULE_15]
        status_clock_o <= started && system_clock_out_o; // [RULE_14]
      end
    end
  end

  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  property p_strap;
    (enable_i && !strap_done && strap_cnt == dsp_pkg::STRAP_WAIT) |=>
      strap_done && scan_mode_o == $past(pin_sync[dsp_pkg::PIN_SEL]);
  endproperty
  a_strap: assert property (p_strap) else $error("strap not captured"); // [RULE_01]
  property p_trst;
    !test_reset_n_i |=> tap_state == dsp_pkg::TAP_RESET && !test_data_oe_o;
  endproperty
  a_trst: assert property (p_trst) else $error("test reset ignored"); // [RULE_02]
  property p_tap_hold;
    !tck_rise |=> $stable(tap_state) || !test_reset_n_i || !$past(test_reset_n_i);
  endproperty
  a_tap_hold: assert property (p_tap_hold) else $error("tap moved off edge"); // [RULE_03]
  property p_oe;
    (tck_fall && test_reset_n_i) |=> test_data_oe_o == $past(shifting);
  endproperty
  a_oe: assert property (p_oe) else $error("tdo enable wrong"); // [RULE_05]
  property p_tdo_fall;
    (test_reset_n_i && $changed(test_data_o)) |-> $past(tck_fall);
  endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("tdo changed off fall"); // [RULE_06]
  property p_valid;
    $changed(dbg_serial_clock_valid) |-> $past(pin_sync[dsp_pkg::PIN_DBG_SERIAL_CLOCK] == pin_last[dsp_pkg::PIN_DBG_SERIAL_CLOCK]);
  endproperty
  a_valid: assert property (p_valid) else $error("unvalidated serial clock"); // [RULE_07]
  property p_dso;
    $changed(dbg_serial_out_o) |-> $past(dbg_serial_clock_rise);
  endproperty
  a_dso: assert property (p_dso) else $error("serial out moved off edge"); // [RULE_09]
  property p_halt;
    $rose(halted_o) |-> $past(halt_pending && instr_done_i);
  endproperty
  a_halt: assert property (p_halt) else $error("halt before instruction end"); // [RULE_11]
  property p_status_f;
    (halted_o && proc_tick && !status_clock_disable_i) |=> proc_status_o == dsp_pkg::ST_HALTED;
  endproperty
  a_status_f: assert property (p_status_f) else $error("halt code missing"); // [RULE_12]
  property p_irq;
    (breakpoint_request_rise && breakpoint_disable_i && !halt_pending) |=> debug_irq_o && !halt_pending;
  endproperty
  a_irq: assert property (p_irq) else $error("disabled breakpoint misbehaved"); // [RULE_13]
  property p_center;
    $rose(status_clock_o) |-> $past(system_clock_out_o) && !system_clock_out_o;
  endproperty
  a_center: assert property (p_center) else $error("status clock off centre"); // [RULE_14]
  property p_freeze;
    (status_clock_disable_i && enable_i) |=>
      $stable(status_clock_o) && $stable(proc_status_o) && $stable(debug_data_out_o);
  endproperty
  a_freeze: assert property (p_freeze) else $error("trace moved while disabled"); // [RULE_15]
  property p_idle;
    !started |=> !status_clock_o;
  endproperty
  a_idle: assert property (p_idle) else $error("status clock before start"); // [RULE_17]
  property p_and;
    status_all_and_o == (&proc_status_o);
  endproperty
  a_and: assert property (p_and) else $error("all-and mismatch"); // [RULE_19]

  c_halt:   cover property ($rose(halted_o));
  c_irq:    cover property (debug_irq_o);
  c_packet: cover property (rx_valid_o);
  c_shift:  cover property (test_data_oe_o);
endmodule : dsp_debug_port
`default_nettype wire

// ===== dsp_pkg.sv
`default_nettype none
package dsp_pkg;
  // pin vector positions for the input synchronisers
  localparam int PIN_W      = 7;
  localparam int PIN_TCK    = 0;
  localparam int PIN_TMS    = 1;
  localparam int PIN_TDI    = 2;
  localparam int PIN_DBG_SERIAL_CLOCK  = 3;
  localparam int PIN_DSIN   = 4;
  localparam int PIN_BREAKPOINT_REQUEST   = 5;
  localparam int PIN_SEL    = 6;
  // strap capture waits until the synchroniser holds the pin level
  localparam logic [1:0] STRAP_WAIT = 2'h2;
  // trace encodings
  localparam logic [3:0] ST_IDLE    = 4'h0;
  localparam logic [3:0] ST_CODE_C  = 4'hC;
  localparam logic [3:0] ST_CODE_D  = 4'hD;
  localparam logic [3:0] ST_HALTED  = 4'hF;
  // scan and serial widths
  localparam int          IR_W       = 4;
  localparam logic [3:0]  IR_CAPTURE = 4'h1;
  localparam logic [3:0]  IR_RESET   = 4'hF;
  localparam int          PKT_BITS   = 16;
  localparam logic [4:0]  PKT_LAST   = 5'h0F;
  // test access port controller states
  typedef enum logic [15:0] {
    TAP_RESET    = 16'h0001,
    TAP_IDLE     = 16'h0002,
    TAP_SEL_DR   = 16'h0004,
    TAP_CAP_DR   = 16'h0008,
    TAP_SHIFT_DR = 16'h0010,
    TAP_EXIT1_DR = 16'h0020,
    TAP_PAUSE_DR = 16'h0040,
    TAP_EXIT2_DR = 16'h0080,
    TAP_UPD_DR   = 16'h0100,
    TAP_SEL_IR   = 16'h0200,
    TAP_CAP_IR   = 16'h0400,
    TAP_SHIFT_IR = 16'h0800,
    TAP_EXIT1_IR = 16'h1000,
    TAP_PAUSE_IR = 16'h2000,
    TAP_EXIT2_IR = 16'h4000,
    TAP_UPD_IR   = 16'h8000
  } dsp_tap_t;
endpackage : dsp_pkg
`default_nettype wire

// ===== dsp_debugger_model.sv
`timescale 1ns/10ps
`default_nettype none
module dsp_debugger_model (
  input  wire logic clock_i,
  input  wire logic scan_out_i,
  input  wire logic scan_out_oe_i,
  input  wire logic dbg_serial_out_i,
  output logic      test_clock_o,
  output logic      test_mode_o,
  output logic      test_data_o,
  output logic      dbg_serial_clock_o,
  output logic      dbg_serial_in_o
);
  // clocks idle low outside frames
  initial begin
    test_clock_o       = 1'b0;
    test_mode_o        = 1'b1;
    test_data_o        = 1'b0;
    dbg_serial_clock_o = 1'b0;
    dbg_serial_in_o    = 1'b0;
  end
  // step whole system periods, moving only after falling edges
  task automatic wait_cycles(input int n);
    repeat (n) @(negedge clock_i);
  endtask : wait_cycles
  // one 400 ns test clock period; output seen just before the rise
  task automatic tap_bit(input logic tms, input logic tdi, output logic tdo, output logic oe);
    test_mode_o  = tms;
    test_data_o  = tdi;
    wait_cycles(4);
    tdo          = scan_out_i;
    oe           = scan_out_oe_i;
    test_clock_o = 1'b1;
    wait_cycles(4);
    test_clock_o = 1'b0;
  endtask : tap_bit
  // one 500 ns serial period, output seen late in the high phase
  task automatic serial_bit(input logic din, output logic dout);
    dbg_serial_in_o    = din;
    wait_cycles(5); // slow enough for a 10 MHz status clock
    dbg_serial_clock_o = 1'b1;
    wait_cycles(5);
    dout               = dbg_serial_out_i;
    dbg_serial_clock_o = 1'b0;
  endtask : serial_bit
  // one-cycle spike on the serial clock, too short to count
  task automatic spike();
    dbg_serial_clock_o = 1'b1;
    wait_cycles(1);
    dbg_serial_clock_o = 1'b0;
    wait_cycles(5);
  endtask : spike
  // released data line shows the inverse of its last level
  task automatic end_frame();
    dbg_serial_in_o = ~dbg_serial_in_o;
    wait_cycles(5);
  endtask : end_frame
endmodule : dsp_debugger_model
`default_nettype wire

// ===== dsp_debug_port_bench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(act, exp) begin comparisons++; if ((act) !== (exp)) begin errors++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (act), (exp)); end end
module dsp_debug_port_bench;
  logic        clock = 1'b0, reset = 1'b1, port_select = 1'b0, test_reset_n = 1'b0;
  logic        breakpoint_request_req = 1'b0, breakpoint_request_dis = 1'b0, status_clock_disable = 1'b0, instr_done = 1'b0, resume = 1'b0;
  logic [3:0]  core_status = 4'h0, core_data = 4'h0, v;
  logic [15:0] tx_word = 16'h0000, w, exp_w;
  logic [15:0] exp_rx[$];
  logic        b, oe;
  localparam logic [4:0] TMS_SEQ = 5'h06; // mode bits from reset to instruction shift
  int          errors = 0, comparisons = 0, irq_seen = 0, n;
  wire logic   tck, tms, tdi, dbg_serial_clock, dsin, tdo, tdo_oe, dbg_serial_out, rx_valid, halted, irq;
  wire logic   scan_mode, sclk, all_and, sys_clk;
  wire logic [3:0]  ir, pst, dd_out;
  wire logic [15:0] rx_word;
  wire logic   tdo_pin = tdo_oe ? tdo : 1'bz;

  dsp_debug_port dsp_debug_port_inst (.clock_i(clock), .reset_i(reset), .enable_i(1'b1),
    .port_select_i(port_select), .test_reset_n_i(test_reset_n), .test_clock_i(tck),
    .test_mode_i(tms), .test_data_i(tdi), .test_data_o(tdo), .test_data_oe_o(tdo_oe),
    .instr_reg_o(ir), .dbg_serial_clock_i(dbg_serial_clock), .dbg_serial_in_i(dsin),
    .dbg_serial_out_o(dbg_serial_out), .rx_word_o(rx_word), .rx_valid_o(rx_valid), .tx_word_i(tx_word),
    .breakpoint_request_i(breakpoint_request_req), .breakpoint_disable_i(breakpoint_request_dis),
    .status_clock_disable_i(status_clock_disable), .instr_done_i(instr_done), .resume_i(resume),
    .core_status_i(core_status), .core_data_i(core_data), .halted_o(halted),
    .debug_irq_o(irq), .scan_mode_o(scan_mode), .system_clock_out_o(sys_clk),
    .status_clock_o(sclk), .proc_status_o(pst), .debug_data_out_o(dd_out),
    .status_all_and_o(all_and));

  dsp_debugger_model dsp_debugger_model_inst (.clock_i(clock), .scan_out_i(tdo_pin),
    .scan_out_oe_i(tdo_oe), .dbg_serial_out_i(dbg_serial_out), .test_clock_o(tck), .test_mode_o(tms),
    .test_data_o(tdi), .dbg_serial_clock_o(dbg_serial_clock), .dbg_serial_in_o(dsin));

  // 20 MHz system clock
  always #25 clock = ~clock;

  task automatic cyc(input int k);
    repeat (k) @(negedge clock);
  endtask : cyc

  task automatic complete_run();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  // reset with a chosen strap, then check the captured mode
  task automatic do_reset(input logic strap);
    reset        = 1'b1;
    test_reset_n = 1'b0;
    port_select  = strap;
    cyc(20);
    reset        = 1'b0;
    test_reset_n = 1'b1;
    cyc(6);
    `CHK(scan_mode, strap)
  endtask : do_reset

  // count status clock changes while feeding random captured data
  task automatic count_sclk(input int k, output int c);
    logic prev;
    c    = 0;
    prev = sclk;
    repeat (k) begin
      core_data = 4'($urandom);
      cyc(1);
      if (sclk !== prev) c++;
      prev = sclk;
    end
  endtask : count_sclk

  // compare each finished packet with the oldest expected word
  always @(negedge clock) begin
    if (rx_valid === 1'b1) begin
      exp_w = (exp_rx.size() > 0) ? exp_rx.pop_front() : 16'hXXXX;
      `CHK(rx_word, exp_w)
    end
    if (irq === 1'b1) irq_seen++;
  end

  // watchdog: the tests need about 30 us
  initial begin
    #200000;
    errors++;
    complete_run();
  end

  initial begin
    void'($urandom(9985));
    do_reset(1'b0);
    count_sclk(30, n);
    `CHK(n, 0)
    core_status = dsp_pkg::ST_CODE_C;
    count_sclk(20, n);
    `CHK(n > 4, 1'b1)
    `CHK(pst, dsp_pkg::ST_CODE_C)
    `CHK(all_and, 1'b0)
    // status clock is the processor clock one system cycle later
    b = sys_clk;
    cyc(1);
    `CHK(sclk, b)
    core_data = 4'($urandom);
    cyc(2);
    `CHK(dd_out, core_data)
    // two packets, a spike between them that must not count
    repeat (2) begin
      w       = 16'($urandom);
      tx_word = 16'($urandom);
      exp_rx.push_back(w);
      for (int i = 15; i >= 0; i--) begin
        dsp_debugger_model_inst.serial_bit(w[i], b);
        `CHK(b, tx_word[i])
      end
      dsp_debugger_model_inst.end_frame();
      dsp_debugger_model_inst.spike();
    end
    `CHK(exp_rx.size(), 0)
    // frozen trace, breakpoint still raises the interrupt
    status_clock_disable = 1'b1;
    cyc(4);
    v = dd_out;
    core_status = dsp_pkg::ST_CODE_D;
    breakpoint_request_dis    = 1'b1;
    breakpoint_request_req    = 1'b1;
    cyc(4);
    breakpoint_request_req    = 1'b0;
    count_sclk(16, n);
    `CHK(n, 0)
    `CHK(pst, dsp_pkg::ST_CODE_C)
    `CHK(dd_out, v)
    `CHK(irq_seen, 1)
    `CHK(halted, 1'b0)
    status_clock_disable = 1'b0;
    count_sclk(16, n); // resynchronise before trusting the trace
    `CHK(n > 4, 1'b1)
    `CHK(pst, dsp_pkg::ST_CODE_D)
    // halt waits for the current instruction
    breakpoint_request_dis = 1'b0;
    breakpoint_request_req = 1'b1;
    cyc(4);
    breakpoint_request_req = 1'b0;
    cyc(6);
    `CHK(halted, 1'b0)
    instr_done = 1'b1;
    cyc(1);
    instr_done = 1'b0;
    for (n = 0; n < 20 && pst !== dsp_pkg::ST_HALTED; n++) cyc(1);
    `CHK(halted, 1'b1)
    `CHK(pst, dsp_pkg::ST_HALTED)
    `CHK(all_and, 1'b1)
    resume = 1'b1;
    cyc(1);
    resume = 1'b0;
    cyc(6);
    `CHK(halted, 1'b0)
    // scan mode: walk to the instruction shift, shift in a new value
    do_reset(1'b1);
    v = 4'($urandom) & 4'h7;
    for (int i = 0; i < 5; i++) dsp_debugger_model_inst.tap_bit(TMS_SEQ[i], 1'b0, b, oe);
    for (int i = 0; i < 4; i++) begin
      dsp_debugger_model_inst.tap_bit(i == 3, v[i], b, oe);
      `CHK(oe, 1'b1)
      `CHK(b, dsp_pkg::IR_CAPTURE[i])
    end
    dsp_debugger_model_inst.tap_bit(1'b1, 1'b0, b, oe);
    `CHK(oe, 1'b0)
    dsp_debugger_model_inst.tap_bit(1'b0, 1'b0, b, oe);
    cyc(4);
    `CHK(ir, v)
    // test reset acts with no clock edge
    test_reset_n = 1'b0;
    #10;
    `CHK(ir, dsp_pkg::IR_RESET)
    `CHK(tdo_oe, 1'b0)
    cyc(4);
    complete_run();
  end
endmodule : dsp_debug_port_bench
`default_nettype wire
